/* File: hw/ssu_top.sv */
// serial slave unit: semaphore-guarded byte mover between an external
// serial master and memory buffers
// assumes config is static during frames, memory read data valid while
// the read strobe stands, and a select-to-first-clock gap of a few ref_clk
`timescale 1ns/100ps
`default_nettype none

module ssu_top
   import ssu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire ssu_cfg_t cfg,
   input wire logic acquire_task,
   input wire logic release_task,
   input wire logic [1:0] status_clear,
   input wire logic [7:0] mem_rdata,
   input wire logic csn_pin,
   input wire logic sck_pin,
   input wire logic mosi_pin,
   output logic miso_o,
   output logic miso_oe,
   output var ssu_mem_t mem,
   output var ssu_evt_t ev,
   output var ssu_stat_t stat,
   output logic [3:0] pin_claim
);

   ssu_core_t c_ff; // core-clock state
   ssu_core_t nxt_c; // its next value
   ssu_lnk_t lk_ff; // capture-edge state
   ssu_lnk_t nxt_lk; // its next value
   ssu_drv_t dr_ff; // drive-edge state
   ssu_drv_t nxt_dr; // its next value
   logic csn_eff; // select as seen by the unit, high when unrouted
   logic sck_routed; // serial clock after routing
   logic sck_eff; // capture edge is always the rising edge of this
   logic mosi_eff; // routed data in
   logic lk_rst_b; // link logic held in reset outside frames
   logic tgl_chg; // a byte finished on the link side
   logic [7:0] cur_tx; // byte being shifted out
   logic [`SSU_CNT_W-1:0] rx_inc; // receive count plus one

   // pin routing only while enabled; unrouted select reads as idle
   assign csn_eff = csn_pin | ~(cfg.enable & cfg.route_connect[`SSU_ROUTE_CSN]);
   // unrouted clock rests at its idle level
   assign sck_routed = (cfg.enable & cfg.route_connect[`SSU_ROUTE_SCK]) ? sck_pin
      : cfg.cpol;
   // folding polarity and phase turns every mode into sample-on-rise
   assign sck_eff = sck_routed ^ cfg.cpol ^ cfg.cpha;
   assign mosi_eff = cfg.route_connect[`SSU_ROUTE_MOSI] & mosi_pin;
   // select doubles as the link reset, so every frame starts clean
   assign lk_rst_b = rst_b & ~csn_eff;

   // capture edge: shift in, count bits, flag each whole byte
   always_comb begin
      nxt_lk = lk_ff;
      nxt_lk.rx_sh = {lk_ff.rx_sh[5:0], mosi_eff};
      nxt_lk.bitcnt = lk_ff.bitcnt + `SSU_BIT_ONE;
      if (lk_ff.bitcnt == `SSU_BIT_LAST) begin
         // byte stays put for eight bit times, long enough to cross
         nxt_lk.rx_byte = {lk_ff.rx_sh, mosi_eff};
         nxt_lk.tgl = ~lk_ff.tgl;
         nxt_lk.par = ~lk_ff.par;
      end
   end

   // capture-edge register
   always_ff @(posedge sck_eff or negedge lk_rst_b) begin
      if (!lk_rst_b) begin
         lk_ff <= '0;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // drive edge: next bit from the byte slot of this parity
   always_comb begin
      // slots are refilled only while the other one is in use
      cur_tx = lk_ff.par ? c_ff.tx_odd : c_ff.tx_even;
      nxt_dr.miso = cur_tx[`SSU_BIT_LAST - lk_ff.bitcnt];
      nxt_dr.drv = 1'b1;
   end

   // drive-edge register, on the falling edge of the folded clock
   always_ff @(negedge sck_eff or negedge lk_rst_b) begin
      if (!lk_rst_b) begin
         dr_ff <= '0;
      end else begin
         dr_ff <= nxt_dr;
      end
   end

   // before the first drive edge the leading bit comes from the slot
   assign miso_o = dr_ff.drv ? dr_ff.miso : c_ff.tx_even[`SSU_BIT_LAST];
   // released whenever not selected or not routed
   assign miso_oe = ~csn_eff & cfg.route_connect[`SSU_ROUTE_MISO];

   assign tgl_chg = c_ff.tgl_s != c_ff.tgl_seen;
   assign rx_inc = c_ff.rx_cnt + `SSU_CNT_ONE;

   // core sequencer, semaphore and memory mover
   always_comb begin
      logic fill; // fetch the next transmit byte this cycle
      fill = 1'b0;
      nxt_c = c_ff;
      nxt_c.ev = '0;
      nxt_c.mem.rd = 1'b0;
      nxt_c.mem.wr = 1'b0;
      // two-stage synchronisers for select and the byte toggle
      nxt_c.csn_m = csn_eff;
      nxt_c.csn_s = c_ff.csn_m;
      nxt_c.tgl_m = lk_ff.tgl;
      nxt_c.tgl_s = c_ff.tgl_m;
      nxt_c.pin_claim = cfg.enable ? cfg.route_connect : `SSU_ROUTE_NONE;

      // software clears of status flags; sets below win
      if (status_clear[0]) begin
         nxt_c.stat.overflow = 1'b0;
      end
      if (status_clear[1]) begin
         nxt_c.stat.overread = 1'b0;
      end

      // read data returns into the slot it was fetched for
      if (c_ff.rd_pend) begin
         nxt_c.rd_pend = 1'b0;
         if (c_ff.rd_par) begin
            nxt_c.tx_odd = mem_rdata;
         end else begin
            nxt_c.tx_even = mem_rdata;
         end
      end

      // release only acts for the software owner
      if (release_task && (c_ff.stat.sem == SSU_SEM_CPU)) begin
         nxt_c.stat.sem = SSU_SEM_FREE;
      end // otherwise no effect

      // acquire task against the current owner
      if (acquire_task && (c_ff.st != SSU_OFF)) begin
         case (c_ff.stat.sem)
            SSU_SEM_CPU: begin
               nxt_c.stat.sem = SSU_SEM_CPU;
               nxt_c.ev.acquired_event = 1'b1;
            end
            SSU_SEM_FREE: begin
               nxt_c.stat.sem = SSU_SEM_CPU;
               nxt_c.ev.acquired_event = 1'b1;
            end
            SSU_SEM_SLV: begin
               nxt_c.acq_pend = 1'b1;
            end
            default: begin
               nxt_c.stat.sem = SSU_SEM_FREE;
            end
         endcase
      end

      case (c_ff.st)
         SSU_OFF: begin
            if (cfg.enable) begin
               // initial handover raises no event
               nxt_c.stat.sem = SSU_SEM_CPU;
               nxt_c.st = SSU_IDLE;
            end
         end
         SSU_IDLE: begin
            nxt_c.tgl_seen = c_ff.tgl_s;
            if (!c_ff.csn_s) begin
               // software request in the same cycle wins
               if ((c_ff.stat.sem == SSU_SEM_FREE) && !acquire_task) begin
                  nxt_c.stat.sem = SSU_SEM_SLV;
                  // pointers are reread per frame, unchanged ones repeat
                  nxt_c.tx_next = `SSU_CNT_ZERO;
                  nxt_c.byte_n = `SSU_CNT_ZERO;
                  nxt_c.rx_cnt = `SSU_CNT_ZERO;
                  nxt_c.tx_cnt = `SSU_CNT_ZERO;
                  nxt_c.stat.overflow = 1'b0;
                  nxt_c.stat.overread = 1'b0;
                  nxt_c.st = SSU_PRE0;
               end else begin
                  // ignored: fill byte for the whole frame
                  nxt_c.tx_even = cfg.ignored_txn_fill_byte;
                  nxt_c.tx_odd = cfg.ignored_txn_fill_byte;
                  nxt_c.st = SSU_IGN;
               end
            end
         end
         SSU_PRE0: begin
            fill = 1'b1; // first byte into the even slot
            nxt_c.st = SSU_PRE1;
         end
         SSU_PRE1: begin
            fill = 1'b1; // second byte into the odd slot
            nxt_c.st = SSU_ACTV;
         end
         SSU_ACTV: begin
            if (tgl_chg) begin
               // a whole byte was exchanged on the link
               nxt_c.tgl_seen = c_ff.tgl_s;
               if (c_ff.rx_cnt < cfg.rx_byte_limit) begin
                  nxt_c.mem.wr = 1'b1;
                  nxt_c.mem.wr_addr = cfg.rx_buffer_pointer
                     + {`SSU_PTR_PAD, c_ff.rx_cnt};
                  nxt_c.mem.wdata = lk_ff.rx_byte;
                  nxt_c.rx_cnt = rx_inc;
                  if (rx_inc == cfg.rx_byte_limit) begin
                     nxt_c.ev.rx_buffer_full_event = 1'b1;
                  end
               end else begin
                  nxt_c.stat.overflow = 1'b1;
               end
               if (c_ff.byte_n < cfg.tx_byte_limit) begin
                  nxt_c.tx_cnt = c_ff.tx_cnt + `SSU_CNT_ONE;
               end else begin
                  nxt_c.stat.overread = 1'b1;
               end
               if (c_ff.byte_n != `SSU_CNT_MAX) begin
                  nxt_c.byte_n = c_ff.byte_n + `SSU_CNT_ONE;
               end
               fill = 1'b1;
            end else if (c_ff.csn_s) begin
               // frame over; a late byte is handled first above
               nxt_c.ev.end_event = 1'b1;
               nxt_c.stat.rx_byte_count = c_ff.rx_cnt;
               nxt_c.stat.tx_byte_count = c_ff.tx_cnt;
               nxt_c.acq_pend = 1'b0;
               if (cfg.short_end_acquire || c_ff.acq_pend || acquire_task) begin
                  // one handover and one event, however many requests
                  nxt_c.stat.sem = SSU_SEM_CPU;
                  nxt_c.ev.acquired_event = 1'b1;
               end else begin
                  nxt_c.stat.sem = SSU_SEM_FREE;
               end
               nxt_c.st = SSU_IDLE;
            end
         end
         SSU_IGN: begin
            // received bytes dropped; a release now does not rescue it
            nxt_c.tgl_seen = c_ff.tgl_s;
            if (c_ff.csn_s) begin
               nxt_c.st = SSU_IDLE;
            end
         end
         default: begin
            nxt_c.st = SSU_OFF;
         end
      endcase

      // fetch next transmit byte or substitute the over-read byte
      if (fill) begin
         if (c_ff.tx_next < cfg.tx_byte_limit) begin
            nxt_c.mem.rd = 1'b1;
            nxt_c.mem.rd_addr = cfg.tx_buffer_pointer + {`SSU_PTR_PAD, c_ff.tx_next};
            nxt_c.rd_pend = 1'b1;
            nxt_c.rd_par = c_ff.tx_next[0];
         end else if (c_ff.tx_next[0]) begin
            nxt_c.tx_odd = cfg.overread_fill_byte;
         end else begin
            nxt_c.tx_even = cfg.overread_fill_byte;
         end
         if (c_ff.tx_next != `SSU_CNT_MAX) begin
            nxt_c.tx_next = c_ff.tx_next + `SSU_CNT_ONE;
         end
      end

      // disabling drops the sequencer, semaphore, pending acquire, events and strobes back to rest
      if (!cfg.enable) begin
         nxt_c.st = SSU_OFF;
         nxt_c.stat.sem = SSU_SEM_FREE;
         nxt_c.acq_pend = 1'b0;
         nxt_c.ev = '0;
         nxt_c.mem.rd = 1'b0;
         nxt_c.mem.wr = 1'b0;
      end
   end

   // core register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         c_ff <= '{st: SSU_OFF, stat: '{sem: SSU_SEM_FREE, default: '0},
            csn_m: 1'b1, csn_s: 1'b1, default: '0};
      end else begin
         c_ff <= nxt_c;
      end
   end

   assign mem = c_ff.mem;
   assign ev = c_ff.ev;
   assign stat = c_ff.stat;
   assign pin_claim = c_ff.pin_claim;

endmodule // ssu_top

`default_nettype wire

/* File: hw/ssu_map.svh */
// constants for the serial slave unit: widths, reset values, field positions
// assumes inclusion by the serial slave package only
//
// Contract
// - all four clock modes via polarity, phase
// - release by software owner frees semaphore
// - release without ownership changes nothing
// - enabling gives semaphore to software silently
// - acquire while software owns: event at once
// - failed grant: drop input, send fill byte
// - simultaneous requests: software wins
// - granted: store received bytes, send buffer bytes
// - select rise ends grant: release, end event
// - repeated grants reuse unchanged pointers
// - shortcut hands semaphore to software after end
// - acquire during slave ownership deferred until end
// - shortcut plus acquire: serve one acquire
// - receive limit exceeded: overflow flag, drop bytes
// - transmit limit exceeded: over-read flag, fill byte
// - counts updated at end, over-reads excluded
// - full receive buffer raises buffer-full event
// - disconnected route leaves signal unattached
// - routes only apply while enabled
// - data out released while not selected
// - fill byte register for ignored transactions
// - shortcut enable bit zero
`ifndef SSU_MAP_SVH
`define SSU_MAP_SVH

`define SSU_CNT_W 13
`define SSU_CNT_ZERO 13'h0000
`define SSU_CNT_ONE 13'h0001
`define SSU_CNT_MAX 13'h1fff
`define SSU_BYTE_RST 8'h00
`define SSU_BIT_LAST 3'h7
`define SSU_BIT_ONE 3'h1
`define SSU_PTR_W 32
`define SSU_ROUTE_CSN 0
`define SSU_ROUTE_SCK 1
`define SSU_ROUTE_MOSI 2
`define SSU_ROUTE_MISO 3
`define SSU_ROUTE_NONE 4'h0
`define SSU_PTR_PAD 19'h00000

`endif

/* File: hw/ssu_pkg.sv */
// types of the serial slave unit: states, semaphore owner, carriers
// assumes ssu_map.svh sits beside it on the include path
`include "ssu_map.svh"

package ssu_pkg;

   // transaction sequencer, one-hot
   typedef enum logic [5:0] {
      SSU_OFF = 6'h01,
      SSU_IDLE = 6'h02,
      SSU_PRE0 = 6'h04,
      SSU_PRE1 = 6'h08,
      SSU_ACTV = 6'h10,
      SSU_IGN = 6'h20
   } ssu_state_t;

   // semaphore owner, one-hot
   typedef enum logic [2:0] {
      SSU_SEM_FREE = 3'h1,
      SSU_SEM_CPU = 3'h2,
      SSU_SEM_SLV = 3'h4
   } ssu_sem_t;

   // software configuration, static while a frame runs
   typedef struct packed {
      logic enable;
      logic cpol;
      logic cpha;
      logic short_end_acquire;
      logic [3:0] route_connect;
      logic [`SSU_PTR_W-1:0] rx_buffer_pointer;
      logic [`SSU_PTR_W-1:0] tx_buffer_pointer;
      logic [`SSU_CNT_W-1:0] rx_byte_limit;
      logic [`SSU_CNT_W-1:0] tx_byte_limit;
      logic [7:0] ignored_txn_fill_byte;
      logic [7:0] overread_fill_byte;
   } ssu_cfg_t;

   // one-cycle event pulses
   typedef struct packed {
      logic acquired_event;
      logic end_event;
      logic rx_buffer_full_event;
   } ssu_evt_t;

   // status seen by software
   typedef struct packed {
      ssu_sem_t sem;
      logic overflow;
      logic overread;
      logic [`SSU_CNT_W-1:0] rx_byte_count;
      logic [`SSU_CNT_W-1:0] tx_byte_count;
   } ssu_stat_t;

   // memory port: read data is taken while rd stands
   typedef struct packed {
      logic rd;
      logic [`SSU_PTR_W-1:0] rd_addr;
      logic wr;
      logic [`SSU_PTR_W-1:0] wr_addr;
      logic [7:0] wdata;
   } ssu_mem_t;

   // capture-edge state on the serial clock
   typedef struct packed {
      logic [6:0] rx_sh;
      logic [2:0] bitcnt;
      logic par;
      logic tgl;
      logic [7:0] rx_byte;
   } ssu_lnk_t;

   // drive-edge state on the serial clock
   typedef struct packed {
      logic miso;
      logic drv;
   } ssu_drv_t;

   // whole core-clock state
   typedef struct packed {
      ssu_state_t st;
      logic acq_pend;
      logic csn_m;
      logic csn_s;
      logic tgl_m;
      logic tgl_s;
      logic tgl_seen;
      logic [7:0] tx_even;
      logic [7:0] tx_odd;
      logic [`SSU_CNT_W-1:0] tx_next;
      logic rd_pend;
      logic rd_par;
      logic [`SSU_CNT_W-1:0] byte_n;
      logic [`SSU_CNT_W-1:0] rx_cnt;
      logic [`SSU_CNT_W-1:0] tx_cnt;
      logic [3:0] pin_claim;
      ssu_evt_t ev;
      ssu_stat_t stat;
      ssu_mem_t mem;
   } ssu_core_t;

endpackage

/* File: verification/ssu_top_chk.sv */
// checker for the serial slave unit: semaphore, events, pins, writes
// assumes a bind onto ssu_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module ssu_top_chk
   import ssu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire ssu_cfg_t cfg,
   input wire logic acquire_task,
   input wire logic release_task,
   input wire logic csn_pin,
   input wire logic miso_oe,
   input wire ssu_mem_t mem,
   input wire ssu_evt_t ev,
   input wire ssu_stat_t stat,
   input wire logic [3:0] pin_claim
);
   // one clock domain, so clocking and reset are given once
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_acq_fast: assert property (
      acquire_task && cfg.enable && stat.sem == SSU_SEM_CPU |=> ev.acquired_event)
      else $error("acquire not answered");
   a_rel_frees: assert property (
      release_task && !acquire_task && stat.sem == SSU_SEM_CPU |=> stat.sem == SSU_SEM_FREE)
      else $error("release did not free");
   // select must have been high long enough that the slave cannot grab it
   a_rel_noop: assert property (
      release_task && !acquire_task && stat.sem == SSU_SEM_FREE && csn_pin && $past(csn_pin)
      && $past(csn_pin, 2) |=> stat.sem == SSU_SEM_FREE)
      else $error("release changed a free semaphore");
   a_en_silent: assert property (
      $rose(cfg.enable) |=> stat.sem == SSU_SEM_CPU && !ev.acquired_event)
      else $error("enable handover wrong");
   a_end_free: assert property (
      ev.end_event |-> stat.sem != SSU_SEM_SLV)
      else $error("slave kept semaphore at end");
   a_oe_idle: assert property (
      csn_pin |-> !miso_oe)
      else $error("data out driven while unselected");
   a_claim_off: assert property (
      !cfg.enable |=> pin_claim == 4'h0)
      else $error("pins claimed while disabled");
   a_wr_limit: assert property (
      mem.wr |-> mem.wr_addr - cfg.rx_buffer_pointer < 32'(cfg.rx_byte_limit))
      else $error("write beyond receive limit");
   a_full_last: assert property (
      ev.rx_buffer_full_event |-> mem.wr
      && mem.wr_addr == cfg.rx_buffer_pointer + 32'(cfg.rx_byte_limit) - 32'h1)
      else $error("buffer full event misplaced");
endmodule // ssu_top_chk

bind ssu_top ssu_top_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
   .acquire_task(acquire_task), .release_task(release_task), .csn_pin(csn_pin),
   .miso_oe(miso_oe), .mem(mem), .ev(ev), .stat(stat), .pin_claim(pin_claim));
`default_nettype wire

/* File: verification/ssu_spi_master.sv */
// serial master model: drives select, link clock and data in
// assumes the bench resolves the data-out wire and calls xfer
`timescale 1ns/100ps
`default_nettype none

module ssu_spi_master (
   output logic csn,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   // idle: deselected, clock parked
   initial begin
      csn = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end

   // three bytes msb first, 64 ns clock only inside the frame
   task automatic xfer(input logic cpol, input logic cpha, input logic [23:0] tx,
      output logic [23:0] rx);
      sck = cpol;
      #7 csn = 1'b0;
      #300;
      for (int i = 23; i >= 0; i--) begin
         if (!cpha) begin
            mosi = tx[i];
            #32 sck = ~cpol;
            rx[i] = miso;
            #32 sck = cpol;
         end else begin
            sck = ~cpol;
            mosi = tx[i];
            #32 sck = cpol;
            rx[i] = miso;
            #32;
         end
      end
      #100 csn = 1'b1;
      // a released line must not keep showing its last bit
      mosi = ~mosi;
      #400;
   endtask
endmodule // ssu_spi_master
`default_nettype wire

/* File: verification/ssu_top_tb_top.sv */
// self-checking bench for the serial slave unit
// assumes the package, checker and master model are compiled first
`timescale 1ns/100ps
`default_nettype none

module ssu_top_tb_top
   import ssu_pkg::*;
();
   logic ref_clk, rst_b, acquire_task, release_task, csn_pin, sck_pin, mosi_pin;
   logic miso_o, miso_oe, miso_w;
   logic [1:0] status_clear;
   logic [7:0] mem_rdata;
   logic [3:0] pin_claim;
   logic [23:0] rx, txb;
   logic [7:0] ram [256];
   ssu_cfg_t cfg;
   ssu_mem_t mem;
   ssu_evt_t ev;
   ssu_stat_t stat;
   int num_errors, total_checks, cyc, n_end, n_acq, n_full, n_wr, e0, a0, f0, w0;

   // undriven data line toggles so a stale bit never looks valid
   assign miso_w = miso_oe ? miso_o : ref_clk;
   // memory answers while the read strobe stands, as the unit samples it
   assign mem_rdata = mem.rd_addr[7:0] ^ 8'h5a;

   ssu_spi_master u_master (.csn(csn_pin), .sck(sck_pin), .mosi(mosi_pin), .miso(miso_w));
   ssu_top u_ssu_top (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
      .acquire_task(acquire_task), .release_task(release_task), .status_clear(status_clear),
      .mem_rdata(mem_rdata), .csn_pin(csn_pin), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
      .miso_o(miso_o), .miso_oe(miso_oe), .mem(mem), .ev(ev), .stat(stat),
      .pin_claim(pin_claim));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // memory writes, event tallies and hang guard
   always @(posedge ref_clk) begin
      if (mem.wr) ram[mem.wr_addr[7:0]] <= mem.wdata;
      n_end <= n_end + (ev.end_event === 1'b1);
      n_acq <= n_acq + (ev.acquired_event === 1'b1);
      n_full <= n_full + (ev.rx_buffer_full_event === 1'b1);
      n_wr <= n_wr + (mem.wr === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // {acquire, release, clear[1:0]} for one cycle
   task automatic pulse(input logic [3:0] v);
      {acquire_task, release_task, status_clear} <= v;
      @(posedge ref_clk);
      {acquire_task, release_task, status_clear} <= 4'h0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic mark();
      e0 = n_end;
      a0 = n_acq;
      f0 = n_full;
      w0 = n_wr;
   endtask

   // one frame, with an optional task pulse in mid-frame
   task automatic frame(input logic [3:0] mid);
      mark();
      fork
         u_master.xfer(cfg.cpol, cfg.cpha, txb, rx);
         begin
            repeat (25) @(posedge ref_clk);
            if (mid != 4'h0) pulse(mid);
         end
      join
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic close_out();
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      acquire_task = 1'b0;
      release_task = 1'b0;
      status_clear = 2'h0;
      cfg = '0;
      cfg.route_connect = 4'hf;
      cfg.rx_buffer_pointer = 32'h200;
      cfg.tx_buffer_pointer = 32'h100;
      cfg.rx_byte_limit = 13'h0002;
      cfg.tx_byte_limit = 13'h0002;
      cfg.ignored_txn_fill_byte = 8'hd5;
      cfg.overread_fill_byte = 8'h0f;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      cfg.enable <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(stat.sem, SSU_SEM_CPU);
      mark();
      pulse(4'h8);
      chk(n_acq - a0, 1);
      pulse(4'h4);
      chk(stat.sem, SSU_SEM_FREE);
      pulse(4'h4);
      chk(stat.sem, SSU_SEM_FREE);
      // all four modes, same pointers each time: buffer is overwritten
      for (int m = 0; m < 4; m++) begin
         {cfg.cpol, cfg.cpha} <= 2'(m);
         txb = 24'h3c817e ^ {3{8'(m)}};
         @(posedge ref_clk);
         frame(4'h0);
         chk(rx, 24'h5a5b0f);
         chk({ram[0], ram[1]}, txb[23:8]);
         chk(n_wr - w0, 2);
         chk({stat.overflow, stat.overread}, 2'h3);
         chk({stat.rx_byte_count, stat.tx_byte_count}, {13'h2, 13'h2});
         chk({n_end - e0, n_full - f0}, {32'd1, 32'd1});
         chk(stat.sem, SSU_SEM_FREE);
      end
      pulse(4'h3);
      chk({stat.overflow, stat.overread}, 2'h0);
      // ignored frame, released by software midway
      pulse(4'h8);
      frame(4'h4);
      chk(rx, {3{8'hd5}});
      chk(n_wr - w0 + n_end - e0, 0);
      chk(stat.sem, SSU_SEM_FREE);
      // deferred acquire, shortcut plus acquire, shortcut alone
      for (int s = 0; s < 3; s++) begin
         cfg.short_end_acquire <= (s != 0);
         @(posedge ref_clk);
         frame(s == 2 ? 4'h0 : 4'h8);
         chk(n_acq - a0, 1);
         chk(stat.sem, SSU_SEM_CPU);
         pulse(4'h4);
      end
      cfg.enable <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({pin_claim, miso_oe}, 5'h0);
      cfg.route_connect <= 4'h5;
      @(posedge ref_clk);
      cfg.enable <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(pin_claim, 4'h5);
      close_out();
   end
endmodule // ssu_top_tb_top
`default_nettype wire
